// ---- caes_defs.svh ----
`ifndef CAES_DEFS_SVH
`define CAES_DEFS_SVH

// event codes
`define CAES_EV_LOOKUP 8'h34
`define CAES_EV_VICTIM 8'h37
`define CAES_EV_MISC 8'h39
`define CAES_EV_HAREQ 8'h50
`define CAES_EV_OSB 8'h55
`define CAES_EV_RDCRED 8'h58
`define CAES_EV_INSERT 8'h13
`define CAES_EV_NMSET 8'h64
`define CAES_EV_PMMQOS 8'h67

// control register fields
`define CAES_CTL_EV_MSB 7
`define CAES_CTL_EV_LSB 0
`define CAES_CTL_UM_MSB 15
`define CAES_CTL_UM_LSB 8
`define CAES_CTL_EN_BIT 22
`define CAES_CTL_RESET 32'h0000_0000
`define CAES_FILT_RESET 26'h000_0000
`define CAES_CNT_RESET 32'h0000_0000

// register map: counter slot stride 0x10, word index within slot
`define CAES_SLOT_MSB 5
`define CAES_SLOT_LSB 4
`define CAES_WORD_MSB 3
`define CAES_WORD_LSB 2
`define CAES_WORD_CTL 2'h0
`define CAES_WORD_FILT 2'h1
`define CAES_WORD_CNT 2'h2
`define CAES_MAP_TOP 32'h0000_0040

// lookup filter split: request opcode part and source/home part
`define CAES_LK_OPC_MASK 26'h000_003F
`define CAES_LK_SRC_MASK 26'h3FF_FFC0

// victim filter locality bits and unit-mask groups
`define CAES_VIC_LOCAL_BIT 5
`define CAES_VIC_REMOTE_BIT 7
`define CAES_VIC_STATE_MASK 8'h0F
`define CAES_VIC_TRAFFIC_MASK 8'h30

`endif

// ---- caes_pkg.sv ----
`include "caes_defs.svh"

package caes_pkg;
	// selectable event codes
	typedef enum logic [7:0] {
		CAES_LOOKUP = `CAES_EV_LOOKUP,
		CAES_VICTIM = `CAES_EV_VICTIM,
		CAES_MISC = `CAES_EV_MISC,
		CAES_HAREQ = `CAES_EV_HAREQ,
		CAES_OSB = `CAES_EV_OSB,
		CAES_RDCRED = `CAES_EV_RDCRED,
		CAES_INSERT = `CAES_EV_INSERT,
		CAES_NMSET = `CAES_EV_NMSET,
		CAES_PMMQOS = `CAES_EV_PMMQOS
	} caes_event_e;

	typedef logic [25:0] caes_filter_t;
	typedef logic [7:0] caes_umask_t;
endpackage

// ---- caes_event_select.sv ----
// Behaviour
// - every event countable on counters 0-3
// - lookup mask bit6 M hit, bit7 F hit
// - lookup qualified by extended filter bits 57:32
// - lookup filter 0x841 counts local data reads
// - filter 0x1BC8 all ownership reads, 0x9C8 local
// - filter 0x842 local writes, 0x17C2 remote writes
// - code 0x37 counts victimized lines by state
// - victim filter bit5 local, bit7 remote only
// - victim mask 0x0F filter 0 counts all
// - misc bit0 counts silent snoop evictions
// - misc bit1 counts combining write aliasing
// - misc bit3 counts ownership read shared hits
// - broadcast event counts once per cycle with any selected strobe
// - code 0x58 credit stalls per controller 0-5
// - request mask 0x03 counts reads
// - request mask 0x0C counts writes
// - request mask 0x30 counts exclusive no-data
// - code 0x13 ingress inserts, bit7 writeback queue
// - set conflict bit0 counts snoop filter evictions
// - set conflict bit3 counts tracker rejects
// - qos bit0 slow inserts, bit1 fast inserts
// - lookup with no state bit never counts
// - lookup counts once per lookup strobe
`include "caes_defs.svh"

module caes_event_select
	import caes_pkg::*;
#(
	parameter int NUM_CNT = 4,
	parameter int CNT_W = 32
) (
	// apb clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// cache lookup strobe with matched state and request attributes
	input wire logic cache_lookup_event,
	input wire logic [7:0] lookup_state,
	input wire logic [25:0] lookup_attr,
	// cache victim strobe with victim state and origin
	input wire logic cache_victim_event,
	input wire logic [3:0] victim_state,
	input wire logic victim_io,
	input wire logic victim_ia,
	input wire logic victim_local,
	// miscellaneous strobes
	input wire logic silent_snoop_eviction,
	input wire logic combining_write_alias,
	input wire logic ownership_read_shared_hit,
	input wire logic [1:0] prefetch_misc,
	// broadcast: one strobe per triggering request, by request class
	input wire logic [5:0] opportunistic_snoop_broadcast,
	// memory controller read credit stalls, one per controller
	input wire logic [5:0] read_credit_stall,
	// home side request strobes
	input wire logic [5:0] home_side_request,
	// ingress queue allocations
	input wire logic [7:0] ingress_insert_event,
	// near memory set conflicts
	input wire logic [3:0] near_memory_set_conflict_event,
	// persistent memory qos tracker inserts
	input wire logic [1:0] persistent_mem_qos_occupancy_event
);

	// per counter programming and count state
	logic [31:0] ctl [NUM_CNT];
	caes_filter_t filt [NUM_CNT];
	logic [CNT_W-1:0] cnt [NUM_CNT];
	logic [NUM_CNT-1:0] hit;

	// decoded bus request
	logic [1:0] slot;
	logic [1:0] word;
	logic in_map;
	logic mapped;
	logic wr_take;
	logic [31:0] next_rdata;

	// per-source sub-event vectors, padded to the unit mask width
	caes_umask_t misc_vec;
	caes_umask_t osb_vec;
	caes_umask_t rdcred_vec;
	caes_umask_t hareq_vec;
	caes_umask_t nmset_vec;
	caes_umask_t qos_vec;
	caes_umask_t vic_vec;

	// address decode
	assign slot = paddr[`CAES_SLOT_MSB:`CAES_SLOT_LSB];
	assign word = paddr[`CAES_WORD_MSB:`CAES_WORD_LSB];
	assign in_map = (paddr < `CAES_MAP_TOP) && (32'(slot) < 32'(NUM_CNT));
	assign mapped = in_map && (word != 2'h3) && (paddr[1:0] == 2'h0);
	assign wr_take = psel && penable && pready && pwrite && mapped;

	// gather strobes into unit-mask positions
	assign misc_vec = {2'h0, prefetch_misc, ownership_read_shared_hit, 1'b0,
		combining_write_alias, silent_snoop_eviction};
	assign osb_vec = {2'h0, opportunistic_snoop_broadcast};
	assign rdcred_vec = {2'h0, read_credit_stall};
	assign hareq_vec = {2'h0, home_side_request};
	assign nmset_vec = {4'h0, near_memory_set_conflict_event};
	assign qos_vec = {6'h00, persistent_mem_qos_occupancy_event};
	assign vic_vec = {2'h0, victim_ia, victim_io, victim_state};

	// lookup filter: opcode part and source part each match if clear or overlapping
	function automatic logic lookup_filter_ok(input caes_filter_t f, input caes_filter_t a);
		logic opc_ok;
		logic src_ok;
		opc_ok = ((f & `CAES_LK_OPC_MASK) == 26'h0) || (|(f & a & `CAES_LK_OPC_MASK));
		src_ok = ((f & `CAES_LK_SRC_MASK) == 26'h0) || (|(f & a & `CAES_LK_SRC_MASK));
		return opc_ok && src_ok;
	endfunction

	// victim match: state group and traffic group each optional but one needed, optional locality
	function automatic logic victim_ok(input caes_umask_t um, input caes_filter_t f,
		input caes_umask_t v, input logic loc);
		logic st_ok;
		logic tr_ok;
		logic lc_ok;
		st_ok = ((um & `CAES_VIC_STATE_MASK) == 8'h00) || (|(um & v & `CAES_VIC_STATE_MASK));
		tr_ok = ((um & `CAES_VIC_TRAFFIC_MASK) == 8'h00)
			|| (|(um & v & `CAES_VIC_TRAFFIC_MASK));
		if (!f[`CAES_VIC_LOCAL_BIT] && !f[`CAES_VIC_REMOTE_BIT]) begin
			lc_ok = 1'b1;
		end else begin
			lc_ok = (f[`CAES_VIC_LOCAL_BIT] && loc) || (f[`CAES_VIC_REMOTE_BIT] && !loc);
		end
		return (|(um & (`CAES_VIC_STATE_MASK | `CAES_VIC_TRAFFIC_MASK))) && st_ok
			&& tr_ok && lc_ok;
	endfunction

	// one selector and counter per slot, all slots identical
	generate
		for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
			caes_event_e code;
			caes_umask_t um;
			logic sel_hit;

			// one driver per bit of the shared hit vector
			assign hit[i] = sel_hit;

			assign code = caes_event_e'(ctl[i][`CAES_CTL_EV_MSB:`CAES_CTL_EV_LSB]);
			assign um = ctl[i][`CAES_CTL_UM_MSB:`CAES_CTL_UM_LSB];

			// event selection; any selected sub-event gives a single count
			always_comb begin
				sel_hit = 1'b0;
				unique case (code)
					CAES_LOOKUP: begin
						// state mask and request filter must both hold
						sel_hit = cache_lookup_event && (|(um & lookup_state))
							&& lookup_filter_ok(filt[i], lookup_attr);
					end
					CAES_VICTIM: begin
						sel_hit = cache_victim_event
							&& victim_ok(um, filt[i], vic_vec, victim_local);
					end
					CAES_MISC: begin
						sel_hit = |(um & misc_vec);
					end
					CAES_OSB: begin
						sel_hit = |(um & osb_vec);
					end
					CAES_RDCRED: begin
						sel_hit = |(um & rdcred_vec);
					end
					CAES_HAREQ: begin
						sel_hit = |(um & hareq_vec);
					end
					CAES_INSERT: begin
						sel_hit = |(um & ingress_insert_event);
					end
					CAES_NMSET: begin
						sel_hit = |(um & nmset_vec);
					end
					CAES_PMMQOS: begin
						sel_hit = |(um & qos_vec);
					end
					default: begin
						sel_hit = 1'b0;
					end
				endcase
			end

			// control register
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ctl[i] <= `CAES_CTL_RESET;
				end else if (wr_take && (32'(slot) == i) && (word == `CAES_WORD_CTL)) begin
					ctl[i] <= pwdata;
				end
			end

			// extended filter register
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					filt[i] <= `CAES_FILT_RESET;
				end else if (wr_take && (32'(slot) == i) && (word == `CAES_WORD_FILT)) begin
					filt[i] <= pwdata[25:0];
				end
			end

			// counter: software load wins over an increment in the same cycle
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt[i] <= CNT_W'(`CAES_CNT_RESET);
				end else if (wr_take && (32'(slot) == i) && (word == `CAES_WORD_CNT)) begin
					cnt[i] <= CNT_W'(pwdata);
				end else if (ctl[i][`CAES_CTL_EN_BIT] && hit[i]) begin
					cnt[i] <= cnt[i] + CNT_W'(1);
				end
			end
		end
	endgenerate

	// read data selection for the addressed word
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (mapped) begin
			case (word)
				`CAES_WORD_CTL: next_rdata = ctl[slot];
				`CAES_WORD_FILT: next_rdata = {6'h00, filt[slot]};
				`CAES_WORD_CNT: next_rdata = 32'(cnt[slot]);
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// ready raised after setup so every access ends in its first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end

	// read data captured at setup, held through the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= pwrite ? 32'h0000_0000 : next_rdata;
		end
	end

	// error answer for unmapped or misaligned words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && !penable && !mapped;
		end
	end

endmodule

// ---- caes_event_select_chk.sv ----
module caes_event_select_chk #(
	parameter int NUM_CNT = 4
) (
	// apb side of the block
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// zero-wait slave answering in the access cycle only
	rdy_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	rdy_in_access_a: assert property (pready |-> psel && penable && $past(psel && !penable))
		else $error("answer outside access cycle");
	rdy_one_cycle_a: assert property (pready |=> !pready)
		else $error("answer held too long");
	// refused places of the counter map
	err_with_rdy_a: assert property (pslverr |-> pready)
		else $error("error without answer");
	err_range_a: assert property (pready && paddr >= NUM_CNT * 16 |-> pslverr)
		else $error("address past counters not refused");
	err_align_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access not refused");
	err_word3_a: assert property (pready && paddr[3:2] == 2'h3 |-> pslverr)
		else $error("spare slot word not refused");
	rd_zero_a: assert property (pready && (pslverr || pwrite) |-> prdata == 32'h0)
		else $error("read data not zero");
endmodule

bind caes_event_select caes_event_select_chk #(.NUM_CNT(NUM_CNT)) i_chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr
);

// ---- caes_agent_model.sv ----
module caes_agent_model (
	// clock and traffic gate
	input wire logic pclk,
	input wire logic run,
	// packed pipeline strobes
	output logic [79:0] ev
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [79:0] r;
	logic [5:0] want, credit;
	// fresh activity every cycle, back-to-back pulses allowed
	always @(posedge pclk) begin
		r <= 80'({$urandom, $urandom, $urandom});
		want <= 6'($urandom);
		credit <= 6'($urandom);
	end
	// a wanted read without memory controller read credit shows as a stall; quiet while idle
	assign ev = run ? {r[79:60], want & ~credit, r[53:9], 8'h01 << r[3:1], r[0]}
		: 80'h0;
endmodule

// ---- caes_event_select_bench.sv ----
module caes_event_select_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'h0;
	logic presetn, psel, penable, pwrite, run, er, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [79:0] ev;
	logic [41:0] cur;
	logic [31:0] mctl [4];
	logic [25:0] mflt [4];
	int exp [4];
	int err_count, num_checks;
	logic [7:0] codes [10] = '{8'h34, 8'h37, 8'h39, 8'h50, 8'h55, 8'h58, 8'h13, 8'h64, 8'h67, 8'h99};
	// unit mask, event code, filter for four counters a round
	logic [41:0] tbl [24] = '{
		{8'hFF,8'h34,26'h841}, {8'hC0,8'h34,26'h0}, {8'hFF,8'h34,26'h1BC8},
		{8'hFF,8'h34,26'h9C8}, {8'hFF,8'h34,26'h842}, {8'hFF,8'h34,26'h17C2},
		{8'h00,8'h34,26'h0}, {8'hFF,8'h34,26'h8}, {8'h0F,8'h37,26'h0},
		{8'h01,8'h37,26'h20}, {8'h0F,8'h37,26'h80}, {8'h30,8'h37,26'h0},
		{8'h01,8'h39,26'h0}, {8'h02,8'h39,26'h0}, {8'h08,8'h39,26'h0},
		{8'h3F,8'h55,26'h0}, {8'h21,8'h58,26'h0}, {8'h03,8'h50,26'h0},
		{8'h0C,8'h50,26'h0}, {8'h30,8'h50,26'h0}, {8'h80,8'h13,26'h0},
		{8'h01,8'h64,26'h0}, {8'h08,8'h64,26'h0}, {8'h03,8'h67,26'h0}
	};
	caes_agent_model i_caes_agent_model (.pclk, .run, .ev);
	caes_event_select i_caes_event_select (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.cache_lookup_event(ev[0]), .lookup_state(ev[8:1]), .lookup_attr(ev[34:9]),
		.cache_victim_event(ev[35]), .victim_state(ev[39:36]), .victim_io(ev[40]),
		.victim_ia(ev[41]), .victim_local(ev[42]), .silent_snoop_eviction(ev[43]),
		.combining_write_alias(ev[44]), .ownership_read_shared_hit(ev[45]),
		.prefetch_misc(ev[47:46]), .opportunistic_snoop_broadcast(ev[53:48]),
		.read_credit_stall(ev[59:54]), .home_side_request(ev[65:60]),
		.ingress_insert_event(ev[73:66]), .near_memory_set_conflict_event(ev[77:74]),
		.persistent_mem_qos_occupancy_event(ev[79:78])
	);
	// clock, 8 ns period
	always #4 pclk = ~pclk;
	// reference match of one cycle's strobes against a counter setup
	function automatic bit hit(logic [31:0] c, logic [25:0] f, logic [79:0] e);
		logic [7:0] u;
		u = c[15:8];
		case (c[7:0])
			8'h34: return e[0] && |(u & e[8:1]) && (f[5:0] == 0 || |(f[5:0] & e[14:9]))
				&& (f[25:6] == 0 || |(f[25:6] & e[34:15]));
			8'h37: return e[35] && |u[5:0] && (u[3:0] == 0 || |(u[3:0] & e[39:36]))
				&& (u[5:4] == 0 || |(u[5:4] & e[41:40])) && (!f[5] || e[42]) && (!f[7] || !e[42]);
			8'h39: return |(u[5:0] & {e[47:45], 1'h0, e[44:43]});
			8'h55: return |(u[5:0] & e[53:48]);
			8'h58: return |(u[5:0] & e[59:54]);
			8'h50: return |(u[5:0] & e[65:60]);
			8'h13: return |(u & e[73:66]);
			8'h64: return |(u[3:0] & e[77:74]);
			8'h67: return |(u[1:0] & e[79:78]);
			default: return 0;
		endcase
	endfunction
	// reference counts, one per qualifying cycle
	always @(posedge pclk)
		for (int i = 0; i < 4; i++)
			if (mctl[i][22] === 1'h1 && hit(mctl[i], mflt[i], ev))
				exp[i]++;
	task automatic complete_run();
		if (err_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] x, y);
		num_checks++;
		if (y !== x) begin
			err_count++;
			$display("[FAIL] %s exp %h got %h", s, x, y);
		end
	endtask
	// one apb transfer, result left in rd and er
	task automatic apb(input logic w, input logic [31:0] a, d);
		int n;
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1) begin
			err_count++;
			complete_run();
		end else begin
			@(posedge pclk);
		end
	endtask
	task automatic cfg(input int i, input logic [31:0] c, input logic [25:0] f);
		mctl[i] = c;
		mflt[i] = f;
		exp[i] = 0;
		apb(1'h1, 32'(i * 16), c);
		apb(1'h1, 32'(i * 16 + 4), 32'(f));
		apb(1'h1, 32'(i * 16 + 8), 32'h0);
	endtask
	initial begin
		void'($urandom(6759));
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		run = 1'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		// reset contents and refused places
		for (int a = 0; a < 68; a += 2) begin
			apb(1'h0, 32'(a), 32'h0);
			chk("rdata", 32'h0, rd);
			chk("slverr", 32'(a >= 64 || a % 4 != 0 || a % 16 == 12), 32'(er));
		end
		apb(1'h1, 32'h2, 32'h0040_FF34);
		apb(1'h1, 32'h40, 32'h0040_FF34);
		apb(1'h0, 32'h0, 32'h0);
		chk("ctl0", 32'h0, rd);
		apb(1'h1, 32'h34, 32'hFFFF_FFFF);
		apb(1'h0, 32'h34, 32'h0);
		chk("filt3", 32'h03FF_FFFF, rd);
		// fixed rounds, then random setups with random enable
		for (int k = 0; k < 36; k += 4) begin
			for (int i = 0; i < 4; i++) begin
				cur = k < 24 ? tbl[k + i]
					: {8'($urandom), codes[$urandom % 10], 26'($urandom) & 26'h3FF_FF7F};
				cfg(i, {9'h0, k < 24 || 1'($urandom), 6'h0, cur[41:26]}, cur[25:0]);
			end
			run <= 1'h1;
			repeat (300) @(posedge pclk);
			run <= 1'h0;
			repeat (2) @(posedge pclk);
			for (int i = 0; i < 4; i++) begin
				apb(1'h0, 32'(i * 16 + 8), 32'h0);
				chk("count", 32'(exp[i]), rd);
			end
		end
		complete_run();
	end
endmodule
